/* verification/rler_checker.sv */
// port assertions for the retry limit and error report block
`timescale 1ns/1ps
module rler_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic cmd_serr_en,
  input wire logic p_dt_expire,
  input wire logic s_dt_expire,
  input wire logic pw_perr,
  input wire logic p_retry_discard,
  input wire logic s_retry_discard,
  input wire logic p_dt_discard,
  input wire logic s_dt_discard,
  input wire logic perr_discard,
  input wire logic serr_n,
  input wire logic sys_err_status_set
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  pdt_discard_a: assert property (p_dt_expire |=> p_dt_discard)
    else $error("primary timer expiry not discarded");
  sdt_discard_a: assert property (s_dt_expire |=> s_dt_discard)
    else $error("secondary timer expiry not discarded");
  perr_discard_a: assert property (pw_perr |=> perr_discard)
    else $error("posted write parity error not discarded");
  serr_gate_a: assert property (!$past(cmd_serr_en) |-> serr_n)
    else $error("system error while command enable is off");
  status_pair_a: assert property (sys_err_status_set == !serr_n)
    else $error("status set not paired with system error");
  serr_cause_a: assert property (!serr_n |-> p_retry_discard ||
    s_retry_discard || p_dt_discard || s_dt_discard || perr_discard)
    else $error("system error without a discard");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside the read cycle");
  retry_once_a: assert property (p_retry_discard |=> !p_retry_discard)
    else $error("retry discard repeated without new request");
endmodule
bind rler_top rler_checker rler_checker_i (.clk, .rst, .reg_rd, .reg_rdata,
  .cmd_serr_en, .p_dt_expire, .s_dt_expire, .pw_perr, .p_retry_discard,
  .s_retry_discard, .p_dt_discard, .s_dt_discard, .perr_discard, .serr_n,
  .sys_err_status_set);

/* verification/rler_far_model.sv */
// bus agent that opens a request and then retries it a given number of times
`timescale 1ns/1ps
module rler_far_model (
  input wire logic clk,
  input wire logic go,
  input wire logic [9:0] n,
  output logic req_start,
  output logic retry
);
  // a known count keeps retry low until the first request
  logic [9:0] left_r = 10'h000;
  always @(posedge clk) begin
    req_start <= go;
    retry <= !go && left_r != 10'h000;
    left_r <= go ? n : left_r - (left_r != 10'h000);
  end
endmodule

/* verification/tb_rler_top.sv */
// testbench for the retry limit and error report block
`timescale 1ns/1ps
module tb_rler_top;
  logic clk, rst, reg_wr, reg_rd, cmd_serr_en, bctl_dt_serr_en, serr_n, irq;
  logic p_rs, p_rt, s_rs, s_rt, sys_err_status_set, perr_discard;
  logic p_retry_discard, s_retry_discard, p_dt_discard, s_dt_discard;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [2:0] ev;
  logic [1:0] go;
  logic [9:0] n;
  int err_count = 0, num_checks = 0, cyc = 0;
  logic [7:0] ofs [6] = '{8'h5C, 8'h60, 8'h64, 8'h6C, 8'h7C, 8'h70};
  logic [7:0] dis [3] = '{8'h10, 8'h04, 8'h08};
  rler_top rler_top_i (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .cmd_serr_en, .bctl_dt_serr_en, .p_req_start(p_rs),
    .p_retry(p_rt), .s_req_start(s_rs), .s_retry(s_rt),
    .p_dt_expire(ev[2]), .s_dt_expire(ev[1]), .pw_perr(ev[0]),
    .p_retry_discard, .s_retry_discard, .p_dt_discard, .s_dt_discard,
    .perr_discard, .serr_n, .sys_err_status_set, .irq);
  rler_far_model rler_far_model_i (.clk, .go(go[0]), .n,
    .req_start(p_rs), .retry(p_rt));
  rler_far_model rler_far_model_i2 (.clk, .go(go[1]), .n,
    .req_start(s_rs), .retry(s_rt));
  task report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] x);
    num_checks++;
    if (g !== x) begin
      err_count++;
      $display("MISMATCH %0t got %h expected %h", $time, g, x);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) begin
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
    end
    @(posedge clk) reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x);
    @(posedge clk) begin
      reg_rd <= 1'b1;
      reg_addr <= a;
    end
    @(posedge clk) reg_rd <= 1'b0;
    #1 chk(reg_rdata, x);
  endtask
  task fire(input logic [2:0] v, input logic es);
    @(posedge clk) ev <= v;
    @(posedge clk) ev <= 3'h0;
    #1 chk({p_dt_discard, s_dt_discard, perr_discard}, v);
    chk(!serr_n, es);
  endtask
  task retry(input logic s, input logic [9:0] k, input logic ed, es);
    logic d, e;
    d = 1'b0;
    e = 1'b0;
    @(posedge clk) begin
      go <= {s, !s};
      n <= k;
    end
    @(posedge clk) go <= 2'h0;
    repeat (k + 4) begin
      @(posedge clk) #1;
      d = d | (s ? s_retry_discard : p_retry_discard);
      e = e | !serr_n;
    end
    chk(d, ed);
    chk(e, es);
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      report_and_stop;
    end
  end
  initial begin
    {rst, bctl_dt_serr_en} = 2'h3;
    {reg_wr, reg_rd, cmd_serr_en, ev, go, n} = '0;
    {reg_addr, reg_wdata} = '0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    foreach (ofs[i]) rd(ofs[i], 32'h0);
    wr(8'h5C, 32'hFF);
    rd(8'h5C, 32'h1F);
    wr(8'h60, 32'h7EFE_FEFF);
    rd(8'h60, 32'h0);
    wr(8'h64, 32'h8000_0000);
    rd(8'h64, 32'h8000_0000);
    wr(8'h6C, 32'hF);
    rd(8'h6C, 32'h0);
    $display("test registers done");
    wr(8'h5C, 32'h0);
    fire(3'h1, 1'b0);
    @(posedge clk) cmd_serr_en <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      wr(8'h5C, 32'h0);
      fire(3'h1 << i, 1'b1);
      wr(8'h5C, {24'h0, dis[i]});
      fire(3'h1 << i, 1'b0);
    end
    wr(8'h5C, 32'h0);
    @(posedge clk) bctl_dt_serr_en <= 1'b0;
    fire(3'h4, 1'b0);
    fire(3'h2, 1'b0);
    rd(8'h6C, 32'hC);
    rd(8'h6C, 32'h0);
    $display("test timers done");
    wr(8'h60, 32'h0000_0100);
    wr(8'h7C, 32'h2);
    rd(8'h7C, 32'h2);
    retry(1'b0, 10'd255, 1'b0, 1'b0);
    retry(1'b0, 10'd256, 1'b1, 1'b1);
    chk(irq, 1'b1);
    rd(8'h6C, 32'h2);
    chk(irq, 1'b0);
    wr(8'h64, 32'h0);
    retry(1'b1, 10'd300, 1'b0, 1'b0);
    wr(8'h64, 32'h0000_0100);
    wr(8'h5C, 32'h1);
    retry(1'b1, 10'd256, 1'b1, 1'b0);
    wr(8'h5C, 32'h0);
    retry(1'b1, 10'd256, 1'b1, 1'b1);
    rd(8'h6C, 32'h1);
    $display("test retries done");
    report_and_stop;
  end
endmodule

/* verilog/rler_pkg.sv */
// constants for the retry limit and error report register bank
package rler_pkg;
  // register offsets (byte addresses)
  localparam logic [7:0] RLER_OFS_SERR_DIS = 8'h5C;
  localparam logic [7:0] RLER_OFS_P_LIMIT = 8'h60;
  localparam logic [7:0] RLER_OFS_S_LIMIT = 8'h64;
  localparam logic [7:0] RLER_OFS_STATUS = 8'h6C;
  localparam logic [7:0] RLER_OFS_IRQ_MASK = 8'h7C;
  // writable bits, and the implemented status bits (status is not writable)
  localparam logic [7:0] RLER_SED_MASK = 8'h1F;
  localparam logic [31:0] RLER_LIM_MASK = 32'h8101_0100;
  localparam logic [3:0] RLER_ST_MASK = 4'hF;
  // reset values
  localparam logic [7:0] RLER_SED_RST = 8'h00;
  localparam logic [31:0] RLER_LIM_RST = 32'h0000_0000;
  localparam logic [3:0] RLER_ST_RST = 4'h0;
  localparam logic [3:0] RLER_MSK_RST = 4'h0;
  // system-error disable fields
  localparam int RLER_SED_S_RETRY = 0;
  localparam int RLER_SED_P_RETRY = 1;
  localparam int RLER_SED_S_DT = 2;
  localparam int RLER_SED_P_DT = 3;
  localparam int RLER_SED_PW_PERR = 4;
  // retry and timer status fields
  localparam int RLER_ST_S_RETRY = 0;
  localparam int RLER_ST_P_RETRY = 1;
  localparam int RLER_ST_S_DT = 2;
  localparam int RLER_ST_P_DT = 3;
  // retry counter index
  localparam int RLER_PRI = 0;
  localparam int RLER_SEC = 1;
endpackage

/* verilog/rler_top.sv */
// retry limit counters, discard handling and system error report
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
module rler_top
  import rler_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic cmd_serr_en,
  input wire logic bctl_dt_serr_en,
  input wire logic p_req_start,
  input wire logic p_retry,
  input wire logic s_req_start,
  input wire logic s_retry,
  input wire logic p_dt_expire,
  input wire logic s_dt_expire,
  input wire logic pw_perr,
  output logic p_retry_discard,
  output logic s_retry_discard,
  output logic p_dt_discard,
  output logic s_dt_discard,
  output logic perr_discard,
  output logic serr_n,
  output logic sys_err_status_set,
  output logic irq
);

  typedef struct packed {
    logic [7:0] sed;
    logic [1:0][31:0] lim;
    logic [1:0][31:0] cnt;
    logic [1:0] done;
    logic [3:0] stat;
    logic [3:0] mask;
    logic [31:0] rdata;
    logic [1:0] rt_disc;
    logic p_dt_disc;
    logic s_dt_disc;
    logic perr_disc;
    logic serr_n;
    logic st_set;
  } rler_state_t;

  rler_state_t st_r;
  rler_state_t st_nxt;

  // count reaches the lowest set limit bit; set bits above it do not change the limit
  function automatic logic lim_hit(
    input logic [31:0] cnt,
    input logic [31:0] lim
  );
    lim_hit = (lim != RLER_LIM_RST) && ((cnt & lim) != 32'h0000_0000);
  endfunction

  // register read decode, reserved bits return zero
  function automatic logic [31:0] rd_mux(
    input rler_state_t s,
    input logic [7:0] a
  );
    case (a)
      RLER_OFS_SERR_DIS: rd_mux = {24'h000000, s.sed & RLER_SED_MASK};
      RLER_OFS_P_LIMIT: rd_mux = s.lim[RLER_PRI] & RLER_LIM_MASK;
      RLER_OFS_S_LIMIT: rd_mux = s.lim[RLER_SEC] & RLER_LIM_MASK;
      RLER_OFS_STATUS: rd_mux = {28'h0000000, s.stat};
      RLER_OFS_IRQ_MASK: rd_mux = {28'h0000000, s.mask};
      default: rd_mux = 32'h0000_0000;
    endcase
  endfunction

  logic [1:0] req_start;
  logic [1:0] retry_in;
  logic [1:0] rt_exp;
  logic [1:0] rt_sed;
  logic serr_any;
  logic [3:0] st_evt;
  logic [3:0] st_clr;
  logic [31:0] cnt_inc;

  assign req_start = {s_req_start, p_req_start};
  assign retry_in = {s_retry, p_retry};
  assign rt_sed = {st_r.sed[RLER_SED_S_RETRY], st_r.sed[RLER_SED_P_RETRY]};

  always_comb begin
    st_nxt = st_r;
    rt_exp = 2'b00;
    cnt_inc = 32'h0000_0000;

    // retry counters, one per interface
    for (int i = 0; i < 2; i++) begin
      cnt_inc = st_r.cnt[i] + 32'h0000_0001;
      if (req_start[i]) begin
        st_nxt.cnt[i] = 32'h0000_0000;
        st_nxt.done[i] = 1'b0;
      end else if (retry_in[i] && !st_r.done[i]) begin
        st_nxt.cnt[i] = cnt_inc;
        if (lim_hit(cnt_inc, st_r.lim[i])) begin
          rt_exp[i] = 1'b1;
          st_nxt.done[i] = 1'b1;
        end
      end
    end

    // status events, index order matches status fields
    st_evt = 4'h0;
    st_evt[RLER_ST_S_RETRY] = rt_exp[RLER_SEC];
    st_evt[RLER_ST_P_RETRY] = rt_exp[RLER_PRI];
    st_evt[RLER_ST_S_DT] = s_dt_expire;
    st_evt[RLER_ST_P_DT] = p_dt_expire;

    // a new request clears the retry status of its interface
    st_clr = 4'h0;
    st_clr[RLER_ST_S_RETRY] = s_req_start;
    st_clr[RLER_ST_P_RETRY] = p_req_start;
    if (reg_rd && reg_addr == RLER_OFS_STATUS) begin
      st_clr = RLER_ST_MASK;
    end
    // set wins over clear
    st_nxt.stat = ((st_r.stat & ~st_clr) | st_evt) & RLER_ST_MASK;

    // discard pulses, issued whatever the disable bits say
    st_nxt.rt_disc = rt_exp;
    st_nxt.p_dt_disc = p_dt_expire;
    st_nxt.s_dt_disc = s_dt_expire;
    st_nxt.perr_disc = pw_perr;

    // system error on the primary bus
    serr_any = 1'b0;
    for (int i = 0; i < 2; i++) begin
      if (rt_exp[i] && !rt_sed[i] && cmd_serr_en) begin
        serr_any = 1'b1;
      end
    end
    if (p_dt_expire && !st_r.sed[RLER_SED_P_DT] &&
        cmd_serr_en && bctl_dt_serr_en) begin
      serr_any = 1'b1;
    end
    if (s_dt_expire && !st_r.sed[RLER_SED_S_DT] &&
        cmd_serr_en && bctl_dt_serr_en) begin
      serr_any = 1'b1;
    end
    if (pw_perr && !st_r.sed[RLER_SED_PW_PERR] && cmd_serr_en) begin
      serr_any = 1'b1;
    end
    st_nxt.serr_n = ~serr_any;
    st_nxt.st_set = serr_any;

    // register writes
    if (reg_wr) begin
      case (reg_addr)
        RLER_OFS_SERR_DIS: begin
          st_nxt.sed = reg_wdata[7:0] & RLER_SED_MASK;
        end
        RLER_OFS_P_LIMIT: begin
          st_nxt.lim[RLER_PRI] = reg_wdata & RLER_LIM_MASK;
        end
        RLER_OFS_S_LIMIT: begin
          st_nxt.lim[RLER_SEC] = reg_wdata & RLER_LIM_MASK;
        end
        RLER_OFS_IRQ_MASK: begin
          st_nxt.mask = reg_wdata[3:0];
        end
        default: begin
        end
      endcase
    end

    // read data stands only in the cycle after the read strobe
    st_nxt.rdata = 32'h0000_0000;
    if (reg_rd) begin
      st_nxt.rdata = rd_mux(st_r, reg_addr);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r.sed <= RLER_SED_RST;
      st_r.lim <= {RLER_LIM_RST, RLER_LIM_RST};
      st_r.cnt <= {32'h0000_0000, 32'h0000_0000};
      st_r.done <= 2'b00;
      st_r.stat <= RLER_ST_RST;
      st_r.mask <= RLER_MSK_RST;
      st_r.rdata <= 32'h0000_0000;
      st_r.rt_disc <= 2'b00;
      st_r.p_dt_disc <= 1'b0;
      st_r.s_dt_disc <= 1'b0;
      st_r.perr_disc <= 1'b0;
      st_r.serr_n <= 1'b1;
      st_r.st_set <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata;
  assign p_retry_discard = st_r.rt_disc[RLER_PRI];
  assign s_retry_discard = st_r.rt_disc[RLER_SEC];
  assign p_dt_discard = st_r.p_dt_disc;
  assign s_dt_discard = st_r.s_dt_disc;
  assign perr_discard = st_r.perr_disc;
  assign serr_n = st_r.serr_n;
  assign sys_err_status_set = st_r.st_set;
  assign irq = |(st_r.stat & st_r.mask);

endmodule
